/* File: pwrc_pkg.sv */
package pwrc_pkg;
   // ---------------------------------------------------------------
   // rails and registers
   // ---------------------------------------------------------------
   localparam int NRAIL = 7;
   // rail index order inside the enable vectors
   localparam int RAIL_SDA = 0;
   localparam int RAIL_SDB = 1;
   localparam int RAIL_SDC = 2;
   localparam int RAIL_BB = 3;
   localparam int RAIL_SLW = 4;
   localparam int RAIL_FIX = 5;
   localparam int RAIL_SEL = 6;
   localparam logic [3:0] ADDR_OUT_EN = 4'h0;
   localparam logic [3:0] ADDR_VSEL = 4'h1;
   localparam logic [3:0] ADDR_SLW_T2 = 4'h2;
   localparam logic [3:0] ADDR_SEL_LVL = 4'h3;
   localparam logic [3:0] ADDR_PG_CTRL = 4'h4;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   localparam logic [3:0] ADDR_REF_SEL = 4'h7;
   // bit 7 of the slewing second target register switches off the
   // selectable linear regulator
   localparam int SLW_T2_SEL_OFF = 7;
   localparam int PG_SLEW_MASK_OFF = 0;
   localparam logic [7:0] OUT_EN_RST = 8'h7F;
   localparam logic [7:0] VSEL_RST = 8'h00;
   localparam logic [7:0] SLW_T2_RST = 8'h00;
   localparam logic [7:0] SEL_LVL_RST = 8'h00;
   localparam logic [7:0] PG_CTRL_RST = 8'h00;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int DEB_MS = 50;
   localparam int WAKE_MS = 400;
   localparam int HARD_S = 5;
   localparam int HOLD_S = 1;
   localparam int ACK_S = 5;
   localparam int EN_US = 200;
   localparam longint DEB_CYC = longint'(DEB_MS) * 1000 * CLK_MHZ;
   localparam longint WAKE_CYC = longint'(WAKE_MS) * 1000 * CLK_MHZ;
   localparam longint HARD_CYC = longint'(HARD_S) * 1000000 * CLK_MHZ;
   localparam longint HOLD_CYC = longint'(HOLD_S) * 1000000 * CLK_MHZ;
   localparam longint ACK_CYC = longint'(ACK_S) * 1000000 * CLK_MHZ;
   localparam longint EN_CYC = longint'(EN_US) * CLK_MHZ;
   typedef enum logic [1:0] {
      PW_OFF = 2'b00,
      PW_WAKE = 2'b01,
      PW_ON = 2'b11,
      PW_HARD = 2'b10
   } pwrc_state_e;
endpackage

/* File: pwrc_top.sv */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - reset out low while always-on rail bad or during hard reset
// - each regulator enable pin is active high
// - base variant: shared linear enable drives fixed and selectable
// - alternate variant: shared enable drives only fixed linear
// - software can switch off selectable linear by two registers
// - interrupt out asserts on good, undervoltage, overtemp events
// - interrupt stays until host writes interrupt clear register
// - acknowledge high activates wake, low deactivates it
// - wake releases high on detected button press
// - button status follows button after 50ms debounce
// - low on button input means pressed
// - standby pin high forces all references to second target
// - rails-ok low on any bad enabled rail or unmasked slew
// - rails-ok low when every regulator is disabled
// - registers return to defaults on logic supply collapse
// - selectable linear output level set by register
// - button held 400ms releases wake high
// - button held 5s: all off, wake low, reset 1s, inputs ignored 1s
// - enable pins reach regulator after about 200us
// - regulator not re-enabled until output sensed below 300mV
module pwrc_top #(
   parameter bit ALT_VARIANT = 1'b0,
   parameter longint DEB_CYC = pwrc_pkg::DEB_CYC,
   parameter longint WAKE_CYC = pwrc_pkg::WAKE_CYC,
   parameter longint HARD_CYC = pwrc_pkg::HARD_CYC,
   parameter longint HOLD_CYC = pwrc_pkg::HOLD_CYC,
   parameter longint ACK_CYC = pwrc_pkg::ACK_CYC,
   parameter longint EN_CYC = pwrc_pkg::EN_CYC
) (
   // clock and reset (reset is logic supply collapse)
   input wire logic mclk,
   input wire logic rst_n,
   // pins
   input wire logic stepdown_a_enable,
   input wire logic stepdown_b_enable,
   input wire logic stepdown_c_enable,
   input wire logic buckboost_enable,
   input wire logic slewing_linear_enable,
   input wire logic shared_linear_enable,
   input wire logic button_n,
   input wire logic power_hold_ack,
   input wire logic standby_target_select,
   // analog status
   input wire logic always_on_good,
   input wire logic [6:0] rail_good,
   input wire logic [6:0] rail_discharged,
   input wire logic [3:0] rail_slewing,
   input wire logic undervolt_evt,
   input wire logic overtemp_evt,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // outputs
   output logic [6:0] rail_enable,
   output logic [3:0] ref_use_second,
   output logic [1:0] sel_linear_level,
   output logic reset_out_n,
   output logic irq_out_n,
   output logic rails_ok_out,
   output logic button_status_n,
   output logic wake_out
);
   localparam int NR = pwrc_pkg::NRAIL;
   localparam int CW = 40;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [8:0] raw_in;
   logic [8:0] s1_q, s2_q, s3_q, syn_q;
   assign raw_in = {standby_target_select, power_hold_ack, button_n,
      shared_linear_enable, slewing_linear_enable, buckboost_enable,
      stepdown_c_enable, stepdown_b_enable, stepdown_a_enable};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // button stages start released, matching its pulled-up idle level
         s1_q <= 9'h040;
         s2_q <= 9'h040;
         s3_q <= 9'h040;
         syn_q <= 9'h040;
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < 9; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               syn_q[i] <= s3_q[i];
            end
         end
      end
   end
   logic pressed, ack_s, stb_s;
   assign pressed = !syn_q[6];
   assign ack_s = syn_q[7];
   assign stb_s = syn_q[8];

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] out_en_q, vsel_q, slw_t2_q, sel_lvl_q, pg_ctrl_q;
   logic irq_clr_wr;
   assign irq_clr_wr = reg_wr && reg_addr == pwrc_pkg::ADDR_IRQ_CLR;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_en_q <= pwrc_pkg::OUT_EN_RST;
         vsel_q <= pwrc_pkg::VSEL_RST;
         slw_t2_q <= pwrc_pkg::SLW_T2_RST;
         sel_lvl_q <= pwrc_pkg::SEL_LVL_RST;
         pg_ctrl_q <= pwrc_pkg::PG_CTRL_RST;
      end else if (reg_wr) begin
         unique case (reg_addr)
            pwrc_pkg::ADDR_OUT_EN: out_en_q <= reg_wdata;
            pwrc_pkg::ADDR_VSEL: vsel_q <= reg_wdata;
            pwrc_pkg::ADDR_SLW_T2: slw_t2_q <= reg_wdata;
            pwrc_pkg::ADDR_SEL_LVL: sel_lvl_q <= reg_wdata;
            pwrc_pkg::ADDR_PG_CTRL: pg_ctrl_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // enable delay, discharge interlock
   // ---------------------------------------------------------------
   logic [NR-1:0] pin_en;
   logic [NR-1:0] en_q;
   logic inhibit;
   always_comb begin
      pin_en[pwrc_pkg::RAIL_SDA] = syn_q[0];
      pin_en[pwrc_pkg::RAIL_SDB] = syn_q[1];
      pin_en[pwrc_pkg::RAIL_SDC] = syn_q[2];
      pin_en[pwrc_pkg::RAIL_BB] = syn_q[3];
      pin_en[pwrc_pkg::RAIL_SLW] = syn_q[4];
      pin_en[pwrc_pkg::RAIL_FIX] = syn_q[5];
      pin_en[pwrc_pkg::RAIL_SEL] = ALT_VARIANT ? 1'b0 : syn_q[5];
   end
   genvar g;
   generate
      for (g = 0; g < NR; g++) begin : g_rail
         logic [CW-1:0] dly_q;
         logic want;
         logic en_bit_q;
         assign en_q[g] = en_bit_q;
         assign want = pin_en[g] && out_en_q[g] && !inhibit && !(g ==
            pwrc_pkg::RAIL_SEL && slw_t2_q[pwrc_pkg::SLW_T2_SEL_OFF]);
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               dly_q <= '0;
               en_bit_q <= 1'b0;
            end else begin
               if (!want) begin
                  dly_q <= '0;
                  en_bit_q <= 1'b0;
               end else if (dly_q < CW'(EN_CYC)) begin
                  dly_q <= dly_q + 1'b1;
               end else if (!en_bit_q && rail_discharged[g]) begin
                  en_bit_q <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // button timing and power state
   // ---------------------------------------------------------------
   pwrc_pkg::pwrc_state_e st_q;
   logic [CW-1:0] btn_cnt_q, st_cnt_q;
   logic btn_last_q, deb_q;
   assign inhibit = st_q == pwrc_pkg::PW_HARD;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         btn_cnt_q <= '0;
         btn_last_q <= 1'b0;
         deb_q <= 1'b0;
      end else begin
         btn_last_q <= pressed;
         if (inhibit || pressed != btn_last_q) begin
            btn_cnt_q <= '0;
         end else if (btn_cnt_q != '1) begin
            btn_cnt_q <= btn_cnt_q + 1'b1;
         end
         if (inhibit) begin
            deb_q <= 1'b0;
         end else if (pressed != btn_last_q) begin
            deb_q <= deb_q;
         end else if (btn_cnt_q == CW'(DEB_CYC)) begin
            deb_q <= pressed;
         end
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= pwrc_pkg::PW_OFF;
         st_cnt_q <= '0;
      end else begin
         st_cnt_q <= st_cnt_q + 1'b1;
         if (!inhibit && pressed && btn_last_q &&
             btn_cnt_q == CW'(HARD_CYC)) begin
            st_q <= pwrc_pkg::PW_HARD;
            st_cnt_q <= '0;
         end else begin
            unique case (st_q)
               pwrc_pkg::PW_OFF: begin
                  st_cnt_q <= '0;
                  if (ack_s) begin
                     st_q <= pwrc_pkg::PW_ON;
                  end else if (pressed && btn_cnt_q == CW'(WAKE_CYC)) begin
                     st_q <= pwrc_pkg::PW_WAKE;
                  end
               end
               pwrc_pkg::PW_WAKE: begin
                  if (ack_s) begin
                     st_q <= pwrc_pkg::PW_ON;
                  end else if (st_cnt_q >= CW'(ACK_CYC)) begin
                     st_q <= pwrc_pkg::PW_OFF;
                  end
               end
               pwrc_pkg::PW_ON: begin
                  if (!ack_s) begin
                     st_q <= pwrc_pkg::PW_OFF;
                  end
               end
               pwrc_pkg::PW_HARD: begin
                  if (st_cnt_q >= CW'(HOLD_CYC) - 1'b1) begin
                     st_q <= pwrc_pkg::PW_OFF;
                  end
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt and outputs
   // ---------------------------------------------------------------
   logic [NR-1:0] good_last_q;
   logic irq_q, evt;
   assign evt = (|(good_last_q & ~rail_good & en_q)) || undervolt_evt ||
      overtemp_evt;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         good_last_q <= '0;
         irq_q <= 1'b0;
      end else begin
         good_last_q <= rail_good;
         if (evt) begin
            irq_q <= 1'b1;
         end else if (irq_clr_wr) begin
            irq_q <= 1'b0;
         end
      end
   end
   logic slew_mask;
   assign slew_mask = (|rail_slewing) &&
      !pg_ctrl_q[pwrc_pkg::PG_SLEW_MASK_OFF];
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rail_enable <= '0;
         ref_use_second <= 4'h0;
         sel_linear_level <= 2'h0;
         reset_out_n <= 1'b0;
         irq_out_n <= 1'b1;
         rails_ok_out <= 1'b0;
         button_status_n <= 1'b1;
         wake_out <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         rail_enable <= en_q;
         ref_use_second <= stb_s ? 4'hF : vsel_q[3:0];
         sel_linear_level <= sel_lvl_q[1:0];
         reset_out_n <= always_on_good && !inhibit;
         irq_out_n <= !irq_q;
         rails_ok_out <= (&(rail_good | ~en_q)) && (|en_q) &&
            !slew_mask;
         button_status_n <= !deb_q;
         wake_out <= st_q == pwrc_pkg::PW_WAKE ||
            st_q == pwrc_pkg::PW_ON;
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            unique case (reg_addr)
               pwrc_pkg::ADDR_OUT_EN: reg_rdata <= out_en_q;
               pwrc_pkg::ADDR_VSEL: reg_rdata <= vsel_q;
               pwrc_pkg::ADDR_SLW_T2: reg_rdata <= slw_t2_q;
               pwrc_pkg::ADDR_SEL_LVL: reg_rdata <= sel_lvl_q;
               pwrc_pkg::ADDR_PG_CTRL: reg_rdata <= pg_ctrl_q;
               pwrc_pkg::ADDR_STATUS: reg_rdata <= {irq_q, en_q};
               pwrc_pkg::ADDR_REF_SEL: reg_rdata <= {2'h0, st_q,
                  ref_use_second};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   irq_hold_a: assert property (!irq_out_n && !irq_clr_wr &&
      !$past(irq_clr_wr) |=> !irq_out_n)
      else $error("interrupt released without clear");
   irq_set_a: assert property (evt |=> ##1 !irq_out_n)
      else $error("event did not raise interrupt");
   hard_reset_a: assert property (inhibit |=> !reset_out_n)
      else $error("reset not low in hard reset");
   ao_reset_a: assert property (!always_on_good |=> !reset_out_n)
      else $error("reset not low with always-on rail bad");
   hard_off_a: assert property (inhibit |=> en_q == '0)
      else $error("rail on during hard reset");
   stb_force_a: assert property (stb_s |=> ref_use_second == 4'hF)
      else $error("standby did not force second target");
   all_off_a: assert property (en_q == '0 |=> !rails_ok_out)
      else $error("rails ok with all rails off");
   ack_low_a: assert property (st_q == pwrc_pkg::PW_ON && !ack_s
      |=> ##1 !wake_out)
      else $error("wake kept without acknowledge");
   ack_wake_a: assert property (ack_s && !inhibit &&
      btn_cnt_q != CW'(HARD_CYC) |=> ##1 wake_out)
      else $error("acknowledge did not raise wake");
   sel_off_a: assert property (
      slw_t2_q[pwrc_pkg::SLW_T2_SEL_OFF] |=> !en_q[pwrc_pkg::RAIL_SEL])
      else $error("selectable linear not switched off");
   rail_wait_a: assert property ((en_q & ~$past(en_q) &
      ~$past(rail_discharged)) == '0)
      else $error("rail enabled before discharge");
   hard_cov_c: cover property (st_q == pwrc_pkg::PW_HARD);
   wake_cov_c: cover property (st_q == pwrc_pkg::PW_WAKE ##1
      st_q == pwrc_pkg::PW_ON);
   irq_cov_c: cover property (!irq_out_n ##1 irq_clr_wr);
   btn_cov_c: cover property (!button_status_n ##1 button_status_n);
   rail_cov_c: cover property (!en_q[0] ##1 en_q[0]);
endmodule

/* File: pwrc_host_model.sv */
`timescale 1ns/1ps
module pwrc_host_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // handshake with the power block
   input wire logic wake_out,
   input wire logic ack_allow,
   input wire logic [7:0] ack_lag,
   output logic power_hold_ack
);
   logic [7:0] wait_q;
   // acknowledge a wake after ack_lag+1 cycles with wake_out high, kept inside the deadline
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 8'h00;
         power_hold_ack <= 1'b0;
      end else if (!ack_allow) begin
         wait_q <= 8'h00;
         power_hold_ack <= 1'b0;
      end else if (wake_out && !power_hold_ack) begin
         wait_q <= wait_q + 8'h01;
         if (wait_q == ack_lag) begin
            power_hold_ack <= 1'b1;
         end
      end
   end
endmodule

/* File: tb_pwrc_top.sv */
`timescale 1ns/1ps
module tb_pwrc_top;
   // ---------------------------------------------------------------
   // stimulus and bookkeeping
   // ---------------------------------------------------------------
   localparam longint DEB = 20, WAKE = 40, HARD = 80, HOLD = 30;
   localparam longint ACK = 60, EN = 5;
   logic mclk = 1'b0, rst_n = 1'b0, button_n = 1'b1, standby = 1'b0;
   logic ao_good = 1'b1, uv = 1'b0, ot = 1'b0, reg_wr = 1'b0;
   logic reg_rd = 1'b0, ack_allow = 1'b0, ack;
   logic [5:0] en_pins = 6'h00;
   logic [6:0] good = 7'h7F, dis = 7'h7F, rail_enable, alt_rail_enable;
   logic [3:0] slew = 4'h0, reg_addr = 4'h0, ref_use_second;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, ack_lag = 8'h05;
   logic [1:0] sel_linear_level;
   logic reset_out_n, irq_out_n, rails_ok_out, button_status_n, wake_out;
   int mismatches = 0, total_checks = 0, cycles = 0;
   pwrc_top #(.ALT_VARIANT(1'b0), .DEB_CYC(DEB), .WAKE_CYC(WAKE),
      .HARD_CYC(HARD), .HOLD_CYC(HOLD), .ACK_CYC(ACK), .EN_CYC(EN)) uut (
      .mclk(mclk), .rst_n(rst_n), .stepdown_a_enable(en_pins[0]),
      .stepdown_b_enable(en_pins[1]), .stepdown_c_enable(en_pins[2]),
      .buckboost_enable(en_pins[3]), .slewing_linear_enable(en_pins[4]),
      .shared_linear_enable(en_pins[5]), .button_n(button_n),
      .power_hold_ack(ack), .standby_target_select(standby),
      .always_on_good(ao_good), .rail_good(good), .rail_discharged(dis),
      .rail_slewing(slew), .undervolt_evt(uv), .overtemp_evt(ot),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rail_enable(rail_enable),
      .ref_use_second(ref_use_second), .sel_linear_level(sel_linear_level),
      .reset_out_n(reset_out_n), .irq_out_n(irq_out_n),
      .rails_ok_out(rails_ok_out), .button_status_n(button_status_n),
      .wake_out(wake_out));
   pwrc_top #(.ALT_VARIANT(1'b1), .DEB_CYC(DEB), .WAKE_CYC(WAKE),
      .HARD_CYC(HARD), .HOLD_CYC(HOLD), .ACK_CYC(ACK), .EN_CYC(EN)) uut_alt (
      .mclk(mclk), .rst_n(rst_n), .stepdown_a_enable(en_pins[0]),
      .stepdown_b_enable(en_pins[1]), .stepdown_c_enable(en_pins[2]),
      .buckboost_enable(en_pins[3]), .slewing_linear_enable(en_pins[4]),
      .shared_linear_enable(en_pins[5]), .button_n(button_n),
      .power_hold_ack(ack), .standby_target_select(standby),
      .always_on_good(ao_good), .rail_good(good), .rail_discharged(dis),
      .rail_slewing(slew), .undervolt_evt(uv), .overtemp_evt(ot),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(), .rail_enable(alt_rail_enable),
      .ref_use_second(), .sel_linear_level(), .reset_out_n(),
      .irq_out_n(), .rails_ok_out(), .button_status_n(), .wake_out());
   pwrc_host_model host (.mclk(mclk), .rst_n(rst_n), .wake_out(wake_out),
      .ack_allow(ack_allow), .ack_lag(ack_lag), .power_hold_ack(ack));
   initial begin
      forever #5 mclk = ~mclk;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic test_done();
      if (mismatches == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end
   // cycles end 1ns past the edge so outputs have settled
   task automatic cyc(input longint n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, "register read");
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_defaults();
      rchk(pwrc_pkg::ADDR_OUT_EN, pwrc_pkg::OUT_EN_RST);
      rchk(pwrc_pkg::ADDR_VSEL, pwrc_pkg::VSEL_RST);
      rchk(pwrc_pkg::ADDR_SLW_T2, pwrc_pkg::SLW_T2_RST);
      rchk(pwrc_pkg::ADDR_SEL_LVL, pwrc_pkg::SEL_LVL_RST);
      rchk(pwrc_pkg::ADDR_PG_CTRL, pwrc_pkg::PG_CTRL_RST);
      rchk(4'hA, 8'h00);
      chk(rails_ok_out, 1'b0, "rails ok with all off");
   endtask
   task automatic t_enables();
      en_pins <= 6'h3F;
      cyc(EN + 12);
      chk(rail_enable, 7'h7F, "pin enables");
      chk(alt_rail_enable, 7'h3F, "alt variant shared enable");
      chk(rails_ok_out, 1'b1, "rails ok");
      rchk(pwrc_pkg::ADDR_STATUS, 8'h7F);
      wr(pwrc_pkg::ADDR_OUT_EN, 8'h3F);
      cyc(3);
      chk(rail_enable[6], 1'b0, "software off by enable reg");
      wr(pwrc_pkg::ADDR_OUT_EN, 8'h7F);
      cyc(EN + 12);
      chk(rail_enable[6], 1'b1, "selectable back on");
      wr(pwrc_pkg::ADDR_SLW_T2, 8'h80);
      cyc(3);
      chk(rail_enable[6], 1'b0, "software off by target reg");
      wr(pwrc_pkg::ADDR_SLW_T2, 8'h00);
      slew <= 4'h1;
      cyc(8);
      chk(rails_ok_out, 1'b0, "slew masks rails ok");
      wr(pwrc_pkg::ADDR_PG_CTRL, 8'h01);
      cyc(3);
      chk(rails_ok_out, 1'b1, "slew mask disabled");
      slew <= 4'h0;
      wr(pwrc_pkg::ADDR_SEL_LVL, 8'h02);
      cyc(2);
      chk(sel_linear_level, 2'h2, "linear level");
      dis[0] <= 1'b0;
      en_pins[0] <= 1'b0;
      cyc(EN + 12);
      en_pins[0] <= 1'b1;
      cyc(EN + 12);
      chk(rail_enable[0], 1'b0, "re-enable before discharge");
      dis[0] <= 1'b1;
      cyc(EN + 12);
      chk(rail_enable[0], 1'b1, "re-enable after discharge");
   endtask
   task automatic t_irq();
      for (int i = 0; i < 3; i++) begin
         if (i == 0) uv <= 1'b1;
         else if (i == 1) ot <= 1'b1;
         else good[0] <= 1'b0;
         cyc(8);
         if (i == 2) chk(rails_ok_out, 1'b0, "bad rail");
         uv <= 1'b0;
         ot <= 1'b0;
         good <= 7'h7F;
         cyc(4);
         chk(irq_out_n, 1'b0, "interrupt raised");
         wr(pwrc_pkg::ADDR_IRQ_CLR, 8'h00);
         cyc(3);
         chk(irq_out_n, 1'b1, "interrupt cleared");
      end
   endtask
   task automatic t_standby();
      wr(pwrc_pkg::ADDR_VSEL, 8'h05);
      cyc(8);
      chk(ref_use_second, 4'h5, "select bits");
      rchk(pwrc_pkg::ADDR_REF_SEL, 8'h05);
      standby <= 1'b1;
      cyc(8);
      chk(ref_use_second, 4'hF, "standby forces second");
      standby <= 1'b0;
      cyc(8);
      chk(ref_use_second, 4'h5, "standby released");
   endtask
   task automatic t_button();
      button_n <= 1'b0;
      cyc(DEB + 8);
      chk(button_status_n, 1'b0, "status after debounce");
      chk(wake_out, 1'b0, "wake not yet");
      cyc(24);
      chk(wake_out, 1'b1, "wake after hold");
      button_n <= 1'b1;
      cyc(DEB + 8);
      chk(button_status_n, 1'b1, "status released");
      cyc(40);
      chk(wake_out, 1'b0, "wake dropped without ack");
      cyc(HOLD + 5);
      ack_lag <= 8'd40;
      ack_allow <= 1'b1;
      button_n <= 1'b0;
      cyc(WAKE + 12);
      button_n <= 1'b1;
      cyc(ACK + 20);
      chk(wake_out, 1'b1, "wake kept by ack");
      ack_allow <= 1'b0;
      cyc(8);
      chk(wake_out, 1'b0, "wake dropped by ack low");
   endtask
   task automatic t_hard();
      button_n <= 1'b0;
      cyc(HARD + 10);
      chk(reset_out_n, 1'b0, "hard reset out");
      chk(rail_enable, 7'h00, "hard reset rails off");
      chk(wake_out, 1'b0, "hard reset wake low");
      button_n <= 1'b1;
      cyc(10);
      chk(rail_enable, 7'h00, "pins ignored");
      cyc(HOLD + EN + 15);
      chk(reset_out_n, 1'b1, "hard reset over");
      chk(rail_enable, 7'h7F, "pins honoured again");
      ao_good <= 1'b0;
      cyc(6);
      chk(reset_out_n, 1'b0, "always-on rail bad");
      ao_good <= 1'b1;
      cyc(6);
      chk(reset_out_n, 1'b1, "always-on rail good");
      en_pins <= 6'h00;
      cyc(EN + 12);
      chk(rails_ok_out, 1'b0, "all disabled");
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(6);
      rchk(pwrc_pkg::ADDR_VSEL, pwrc_pkg::VSEL_RST);
   endtask
   initial begin
      cyc(6);
      rst_n <= 1'b1;
      cyc(6);
      t_defaults();
      t_enables();
      t_irq();
      t_standby();
      t_button();
      t_hard();
      test_done();
   end
endmodule
